// ===== ioxd_sys.sv
// System end: runs I/O cycles, decodes group selects, drives speaker.
// Assumes the card end meets it through ioxd_if.sys on the same clock.
`timescale 1ns/1ns
module ioxd_sys (
  input  wire logic                           core_clk,
  input  wire logic                           nrst,
  input  wire logic                           clk_en,
  ioxd_if.sys                                 bus,
  input  wire logic                           req_valid,
  input  wire logic                           req_write,
  input  wire logic [ioxd_pkg::ADDR_W-1:0]    req_addr,
  input  wire logic [ioxd_pkg::DATA_W-1:0]    req_wdata,
  input  wire logic                           audio_src,
  output logic                                req_ready,
  output logic                                rsp_valid,
  output logic [ioxd_pkg::DATA_W-1:0]         rsp_rdata,
  output logic                                speaker_out,
  output logic                                card_a_irq,
  output logic                                card_b_irq,
  output logic                                granted
);
  import ioxd_pkg::*;

  // Idle, strobe phase (stretched by wait), one hold cycle for write data
  typedef enum logic [1:0] {IOXD_IDLE, IOXD_STROBE, IOXD_HOLD} ioxd_state_e;

  ioxd_state_e       state_r;
  logic [1:0]        cnt_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic              write_r;
  logic [GROUPS-1:0] grp_dec_n;
  logic              ctrl2_hit;
  logic              done;

  // Speaker register hit and cycle end; wait low keeps the strobe phase open
  assign ctrl2_hit = (addr_r == CTRL2_ADDR);
  assign done      = (cnt_r == '0) && bus.wait_n; // R10

  //////////////////////////////////////////////////////////////////////////////
  // Cycle sequencer; no cycle starts while the bus is granted away
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= IOXD_IDLE;
      cnt_r   <= '0;
      addr_r  <= '0;
      wdata_r <= RST_DATA;
      write_r <= 1'b0;
    end else if (clk_en) begin
      unique case (state_r)
        IOXD_IDLE: begin
          if (req_valid && req_ready) begin
            state_r <= IOXD_STROBE;
            cnt_r   <= STROBE_CYCLES - 2'h1;
            addr_r  <= req_addr;
            wdata_r <= req_wdata;
            write_r <= req_write;
          end
        end
        IOXD_STROBE: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 2'h1;
          end else if (done) begin // R10
            state_r <= IOXD_HOLD;
          end
        end
        IOXD_HOLD: begin
          state_r <= IOXD_IDLE;
        end
        // Unused code: fall back to idle rather than lock up
        default: begin
          state_r <= IOXD_IDLE;
        end
      endcase
    end
  end

  // Ready only when idle and bus not handed to a master
  // Dropping it on the same edge as a take stops a held request being taken twice
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      req_ready <= 1'b0;
    end else if (clk_en) begin
      req_ready <= (state_r == IOXD_IDLE) && !(req_valid && req_ready) &&
                   bus.bus_request_n && bus.bus_grant_n; // R11
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Group decode: only 00H-3FH selects, three low bits inside a group
  // Anything above 3FH leaves every select high; that range is the cards'
  always_comb begin
    grp_dec_n = '1;
    if (addr_r <= INTERNAL_TOP) begin // R03
      grp_dec_n[addr_r[GROUP_LSB+:3]] = 1'b0; // R04
    end
  end

  // Bus pins, all registered; strobes active during the strobe phase
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bus.addr_lines            <= '0;
      bus.sys_data_out          <= RST_DATA;
      bus.sys_data_oe           <= 1'b0;
      bus.io_write_strobe_n     <= 1'b1;
      bus.io_read_strobe_n      <= 1'b1;
      bus.io_cycle_n            <= 1'b1;
      // No memory cycles are ever run, so the memory select stays parked high
      bus.memory_cycle_n        <= 1'b1; // R07
      bus.irq_acknowledge_n     <= 1'b1;
    end else if (clk_en) begin
      if (state_r == IOXD_IDLE && req_valid && req_ready) begin
        bus.addr_lines            <= req_addr;
        bus.sys_data_out          <= req_wdata;
        bus.sys_data_oe           <= req_write;
        bus.io_cycle_n            <= 1'b0; // R08
        bus.io_write_strobe_n     <= !req_write; // R08
        bus.io_read_strobe_n      <= req_write; // R08
      end else if (state_r == IOXD_STROBE && done) begin
        bus.io_write_strobe_n     <= 1'b1;
        bus.io_read_strobe_n      <= 1'b1;
        bus.io_cycle_n            <= 1'b1;
      end else if (state_r == IOXD_HOLD) begin
        bus.sys_data_oe           <= 1'b0; // Data held one cycle past strobe
      end
    end
  end

  // Group selects, low only while the strobe phase is open; they open a cycle
  // after the address so a card never sees a select over a moving address
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bus.io_group_select_n     <= '1;
      bus.card_a_group_select_n <= 1'b1;
      bus.card_b_group_select_n <= 1'b1;
      bus.shared_group_select_n <= 1'b1;
    end else if (clk_en) begin
      if (state_r == IOXD_STROBE && !done) begin
        bus.io_group_select_n     <= grp_dec_n; // R04
        bus.card_a_group_select_n <= grp_dec_n[CARD_A_GROUP]; // R06
        bus.card_b_group_select_n <= grp_dec_n[CARD_B_GROUP]; // R06
        bus.shared_group_select_n <= grp_dec_n[SHARED_GROUP]; // R06
      end else begin
        bus.io_group_select_n     <= '1;
        bus.card_a_group_select_n <= 1'b1;
        bus.card_b_group_select_n <= 1'b1;
        bus.shared_group_select_n <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data capture at strobe end
  // The card still drives the lines at this edge, its enable lags the strobe
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= RST_DATA;
    end else if (clk_en) begin
      rsp_valid <= (state_r == IOXD_STROBE) && done;
      if (state_r == IOXD_STROBE && done && !write_r) begin
        rsp_rdata <= bus.data_lines;
      end
    end
  end

  // Speaker level is the written bit; tone is software's job
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      speaker_out <= 1'b0;
    end else if (clk_en && state_r == IOXD_STROBE && done && write_r && ctrl2_hit) begin
      speaker_out <= wdata_r[SPK_BIT]; // R01
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus grant only between cycles, so a master never cuts into a strobe
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bus.bus_grant_n <= 1'b1;
      granted         <= 1'b0;
    end else if (clk_en) begin
      if (bus.bus_request_n) begin
        bus.bus_grant_n <= 1'b1;
        granted         <= 1'b0;
      end else if (state_r == IOXD_IDLE && !(req_valid && req_ready)) begin
        bus.bus_grant_n <= 1'b0; // R11
        granted         <= 1'b1;
      end
    end
  end

  // Audio mix and card reset; reset stays low until the first enabled edge
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bus.audio_out    <= 1'b0;
      bus.card_reset_n <= 1'b0;
    end else if (clk_en) begin
      bus.audio_out    <= bus.audio_in | audio_src; // R09
      bus.card_reset_n <= 1'b1;
    end
  end

  // Card interrupts turned active high; one register stage, no filtering
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      card_a_irq <= 1'b0;
      card_b_irq <= 1'b0;
    end else if (clk_en) begin
      card_a_irq <= !bus.card_a_irq_n;
      card_b_irq <= !bus.card_b_irq_n;
    end
  end
endmodule : ioxd_sys

// ===== ioxd_pkg.sv
// Constants shared by both ends of the expansion decode link.
// Assumes a single 125 MHz core clock and an active-low asynchronous reset.
// Operation
// [R01] Speaker follows control register two bit 7
// [R02] Software toggles speaker bit to make tone
// [R03] Internal ports live only at 00H-3FH
// [R04] Eight active-low selects, eight ports each
// [R05] Cards decode and answer only 40H-FFH
// [R06] Shared select goes to bus and connectors
// [R07] Bus expansion is I/O ports only
// [R08] Read/write strobes qualified by memory/io lines
// [R09] Bus audio is input; connectors output it
// [R10] Wait held low stretches the current cycle
// [R11] Grant follows release; master drives only granted
package ioxd_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 8;
  localparam int          GROUPS        = 8;
  localparam int          GROUP_LSB     = 3;
  localparam logic [7:0]  INTERNAL_TOP  = 8'h3F;
  localparam logic [7:0]  EXT_BASE      = 8'h40;
  localparam logic [7:0]  CTRL2_ADDR    = 8'h1D;
  localparam int          SPK_BIT       = 7;
  localparam int          CARD_B_GROUP  = 4;
  localparam int          CARD_A_GROUP  = 5;
  localparam int          SHARED_GROUP  = 7;
  localparam logic [1:0]  STROBE_CYCLES = 2'h2;
  localparam logic [7:0]  RST_DATA      = 8'h00;
endpackage : ioxd_pkg

// ===== ioxd_if.sv
// Expansion link between the system decode end and a card end.
// Assumes both ends share core_clk; data lines are resolved from enables here.
`timescale 1ns/1ns
interface ioxd_if;
  import ioxd_pkg::*;
  logic [ADDR_W-1:0] addr_lines;
  logic [DATA_W-1:0] sys_data_out;
  logic              sys_data_oe;
  logic [DATA_W-1:0] card_data_out;
  logic              card_data_oe;
  logic [DATA_W-1:0] data_lines;
  logic [GROUPS-1:0] io_group_select_n;
  logic              card_a_group_select_n;
  logic              card_b_group_select_n;
  logic              shared_group_select_n;
  logic              io_write_strobe_n;
  logic              io_read_strobe_n;
  logic              memory_cycle_n;
  logic              io_cycle_n;
  logic              irq_acknowledge_n;
  logic              card_a_irq_n;
  logic              card_b_irq_n;
  logic              wait_n;
  logic              bus_request_n;
  logic              bus_grant_n;
  logic              audio_in;
  logic              audio_out;
  logic              card_reset_n;

  // Driven value wins; floating lines read as pulled-up ones
  assign data_lines = sys_data_oe ? sys_data_out :
                      (card_data_oe ? card_data_out : {DATA_W{1'b1}});

  modport sys (
    output addr_lines, sys_data_out, sys_data_oe, io_group_select_n,
           card_a_group_select_n, card_b_group_select_n, shared_group_select_n,
           io_write_strobe_n, io_read_strobe_n, memory_cycle_n, io_cycle_n,
           irq_acknowledge_n, bus_grant_n, audio_out, card_reset_n,
    input  data_lines, card_a_irq_n, card_b_irq_n, wait_n, bus_request_n, audio_in
  );
  modport card (
    input  addr_lines, data_lines, io_group_select_n, card_a_group_select_n,
           card_b_group_select_n, shared_group_select_n, io_write_strobe_n,
           io_read_strobe_n, memory_cycle_n, io_cycle_n, irq_acknowledge_n,
           bus_grant_n, audio_out, card_reset_n,
    output card_data_out, card_data_oe, card_a_irq_n, card_b_irq_n, wait_n,
           bus_request_n, audio_in
  );
endinterface : ioxd_if

// ===== ioxd_card.sv
// Card end: one external I/O port that answers only above the internal space.
// Assumes the system end drives the link through ioxd_if.card on core_clk.
`timescale 1ns/1ns
module ioxd_card (
  input  wire logic                        core_clk,
  input  wire logic                        nrst,
  input  wire logic                        clk_en,
  ioxd_if.card                             bus,
  input  wire logic [ioxd_pkg::ADDR_W-1:0] port_addr,
  input  wire logic [ioxd_pkg::DATA_W-1:0] port_rdata,
  input  wire logic                        stall,
  input  wire logic                        irq_a,
  input  wire logic                        irq_b,
  input  wire logic                        audio,
  input  wire logic                        want_bus,
  output logic [ioxd_pkg::DATA_W-1:0]      port_wdata,
  output logic                             port_wr_pulse,
  output logic                             bus_owned
);
  import ioxd_pkg::*;

  logic hit;
  logic wr_seen_r;

  // Only ports at or above 40H and port_addr, and never memory cycles; a
  // port_addr inside the internal space cannot pull the card below 40H
  assign hit = (bus.addr_lines >= EXT_BASE) && (bus.addr_lines >= port_addr) &&
               !bus.io_cycle_n && bus.memory_cycle_n; // R05 R07

  //////////////////////////////////////////////////////////////////////////////
  // Write capture once per strobe; read drive registered, one cycle behind the read strobe
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      port_wdata        <= RST_DATA;
      port_wr_pulse     <= 1'b0;
      wr_seen_r         <= 1'b0;
      bus.card_data_out <= RST_DATA;
      bus.card_data_oe  <= 1'b0;
      bus.wait_n        <= 1'b1;
    end else if (clk_en) begin
      port_wr_pulse     <= 1'b0;
      if (hit && !bus.io_write_strobe_n && !wr_seen_r) begin
        port_wdata    <= bus.data_lines;
        port_wr_pulse <= 1'b1;
        wr_seen_r     <= 1'b1;
      end else if (bus.io_write_strobe_n) begin
        wr_seen_r     <= 1'b0;
      end
      bus.card_data_oe  <= hit && !bus.io_read_strobe_n && bus.bus_grant_n;
      bus.card_data_out <= port_rdata;
      bus.wait_n        <= !(hit && stall); // R10
    end
  end

  // Request and hold bus; own it only while grant is low
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bus.bus_request_n <= 1'b1;
      bus_owned         <= 1'b0;
      bus.card_a_irq_n  <= 1'b1;
      bus.card_b_irq_n  <= 1'b1;
      bus.audio_in      <= 1'b0;
    end else if (clk_en) begin
      bus.bus_request_n <= !want_bus;
      bus_owned         <= want_bus && !bus.bus_grant_n; // R11
      bus.card_a_irq_n  <= !irq_a;
      bus.card_b_irq_n  <= !irq_b;
      bus.audio_in      <= audio; // R09
    end
  end
endmodule : ioxd_card

// ===== ioxd_asserts.sv
// Checker for the signals of the expansion link between system and card.
// Assumes the bench top wires it beside ioxd_if; one clock domain.
`timescale 1ns/1ns
module ioxd_asserts
  import ioxd_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              nrst,
  input wire logic [ADDR_W-1:0] addr_lines,
  input wire logic [GROUPS-1:0] io_group_select_n,
  input wire logic              card_a_group_select_n,
  input wire logic              card_b_group_select_n,
  input wire logic              shared_group_select_n,
  input wire logic              io_write_strobe_n,
  input wire logic              io_read_strobe_n,
  input wire logic              memory_cycle_n,
  input wire logic              io_cycle_n,
  input wire logic              irq_acknowledge_n,
  input wire logic              wait_n,
  input wire logic              bus_request_n,
  input wire logic              bus_grant_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  // Selects only inside the internal space, one group of eight each
  grp_decode_a: assert property (
    (io_group_select_n != 8'hFF) |-> (!io_cycle_n && addr_lines <= INTERNAL_TOP
      && io_group_select_n == ~(8'h01 << addr_lines[5:3])))
    else $error("group select does not match address");
  card_a_sel_a: assert property (
    card_a_group_select_n == io_group_select_n[CARD_A_GROUP])
    else $error("card A select differs from its group");
  card_b_sel_a: assert property (
    card_b_group_select_n == io_group_select_n[CARD_B_GROUP])
    else $error("card B select differs from its group");
  shared_sel_a: assert property (
    shared_group_select_n == io_group_select_n[SHARED_GROUP])
    else $error("shared select differs from its group");
  // No memory cycles or acknowledges are ever run on the link
  mem_idle_a: assert property (
    memory_cycle_n && irq_acknowledge_n)
    else $error("memory or acknowledge cycle seen");
  strobe_qual_a: assert property (
    (!io_write_strobe_n || !io_read_strobe_n) |-> (!io_cycle_n
      && (io_write_strobe_n || io_read_strobe_n)))
    else $error("strobe without io cycle or both strobes low");
  // Wait low keeps the cycle open; a cycle never hangs forever
  wait_hold_a: assert property (
    (!io_cycle_n && !wait_n) |=> !io_cycle_n)
    else $error("cycle ended while wait held low");
  cycle_len_a: assert property (
    $fell(io_cycle_n) |-> ##[2:40] $rose(io_cycle_n))
    else $error("io cycle length out of bounds");
  grant_cause_a: assert property (
    $fell(bus_grant_n) |-> ($past(bus_request_n) == 1'b0 && io_cycle_n))
    else $error("grant without request or during a cycle");
  grant_idle_a: assert property (
    !bus_grant_n |-> (io_cycle_n && io_write_strobe_n && io_read_strobe_n))
    else $error("bus driven while granted away");
endmodule : ioxd_asserts

// ===== ioxd_tb_top.sv
// Self-checking bench: system end and card end joined through ioxd_if.
// Assumes both ends on one 125 MHz clock; inputs change at falling edges.
`timescale 1ns/1ns
module io_expansion_decode_tb_top;
  import ioxd_pkg::*;
  logic       core_clk, nrst, req_valid, req_write, audio_src, stall;
  logic       irq_a, irq_b, audio, want_bus, req_ready, rsp_valid, speaker_out;
  logic       card_a_irq, card_b_irq, granted, port_wr_pulse, bus_owned;
  logic       oe_seen, wr_seen;
  logic [7:0] req_addr, req_wdata, port_rdata, rsp_rdata, port_wdata, sel_seen;
  logic [2:0] side_seen;
  int         lat, fail_count, n_compared;
  int         cyc = 0;
  ioxd_if bus_if();
  ioxd_sys ioxd_sys_i(.core_clk, .nrst, .clk_en(1'b1), .bus(bus_if.sys), .req_valid,
    .req_write, .req_addr, .req_wdata, .audio_src, .req_ready, .rsp_valid, .rsp_rdata,
    .speaker_out, .card_a_irq, .card_b_irq, .granted);
  ioxd_card ioxd_card_i(.core_clk, .nrst, .clk_en(1'b1), .bus(bus_if.card),
    .port_addr(8'h40), .port_rdata, .stall, .irq_a, .irq_b, .audio, .want_bus,
    .port_wdata, .port_wr_pulse, .bus_owned);
  ioxd_asserts ioxd_asserts_i(.core_clk, .nrst, .addr_lines(bus_if.addr_lines),
    .io_group_select_n(bus_if.io_group_select_n),
    .card_a_group_select_n(bus_if.card_a_group_select_n),
    .card_b_group_select_n(bus_if.card_b_group_select_n),
    .shared_group_select_n(bus_if.shared_group_select_n),
    .io_write_strobe_n(bus_if.io_write_strobe_n), .io_read_strobe_n(bus_if.io_read_strobe_n),
    .memory_cycle_n(bus_if.memory_cycle_n), .io_cycle_n(bus_if.io_cycle_n),
    .irq_acknowledge_n(bus_if.irq_acknowledge_n), .wait_n(bus_if.wait_n),
    .bus_request_n(bus_if.bus_request_n), .bus_grant_n(bus_if.bus_grant_n));
  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; the ceiling is far above the whole sequence
  initial begin
    core_clk = 0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      results;
    end
  end
  // Collect link activity just after each edge, so the drivers never race it
  always @(posedge core_clk) begin
    #1;
    sel_seen &= bus_if.io_group_select_n;
    side_seen &= {bus_if.shared_group_select_n, bus_if.card_a_group_select_n,
                  bus_if.card_b_group_select_n};
    oe_seen |= bus_if.card_data_oe;
    wr_seen |= port_wr_pulse;
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One cycle; stall holds the card busy for st cycles; lat counts to rsp_valid
  task io(input logic w, input logic [7:0] a, input logic [7:0] d, input int st);
    int n;
    n = 0;
    while (!req_ready && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    {req_valid, req_write, req_addr, req_wdata, stall} = {1'b1, w, a, d, st > 0};
    {sel_seen, side_seen, oe_seen, wr_seen} = {8'hFF, 3'h7, 2'b00};
    @(negedge core_clk);
    req_valid = 0;
    lat = 0;
    while (!rsp_valid && lat < 40) begin
      @(negedge core_clk);
      lat++;
      if (lat >= st) stall = 0;
    end
    repeat (2) @(negedge core_clk);
  endtask : io
  task t_speaker;
    io(1, CTRL2_ADDR, 8'h80, 0);
    chk(speaker_out, 1);
    chk(sel_seen, 8'hF7);
    chk(8'(lat), 8'(STROBE_CYCLES));
    io(1, 8'h1C, 8'h00, 0);
    chk(speaker_out, 1);
    io(1, CTRL2_ADDR, 8'h7F, 0);
    chk(speaker_out, 0);
  endtask : t_speaker
  // Every group once, at a different offset inside each block of eight
  task t_groups;
    for (int g = 0; g < 8; g++) begin
      io(0, 8'(g * 9), 8'h00, 0);
      chk(sel_seen, ~(8'h01 << g));
      chk(side_seen, {g != 7, g != 5, g != 4});
    end
  endtask : t_groups
  task t_card;
    port_rdata = 8'h3C;
    io(1, EXT_BASE, 8'hA5, 0);
    chk(sel_seen, 8'hFF);
    chk(port_wdata, 8'hA5);
    chk(wr_seen, 1);
    io(0, 8'hFF, 8'h00, 0);
    chk(rsp_rdata, 8'h3C);
    io(0, INTERNAL_TOP, 8'h00, 0);
    chk(oe_seen, 0);
  endtask : t_card
  task t_wait;
    port_rdata = 8'hC3;
    io(0, 8'h80, 8'h00, 4);
    chk(lat > 3, 1);
    chk(rsp_rdata, 8'hC3);
  endtask : t_wait
  // Interrupt lines and both audio sources mixed onto the connector output
  task t_side;
    {irq_a, irq_b, audio, audio_src} = 4'b1010;
    repeat (4) @(negedge core_clk);
    chk({card_a_irq, card_b_irq, bus_if.audio_out}, 3'b101);
    {irq_a, irq_b, audio, audio_src} = 4'b0101;
    repeat (4) @(negedge core_clk);
    chk({card_a_irq, card_b_irq, bus_if.audio_out}, 3'b011);
    {irq_b, audio_src} = 2'b00;
    repeat (4) @(negedge core_clk);
    chk({card_a_irq, card_b_irq, bus_if.audio_out}, 3'b000);
  endtask : t_side
  task t_grant;
    want_bus = 1;
    for (int i = 0; i < 10 && granted !== 1'b1; i++) @(negedge core_clk);
    // Ownership is registered one edge behind the grant
    @(negedge core_clk);
    chk({granted, bus_owned, req_ready}, 3'b110);
    want_bus = 0;
    for (int i = 0; i < 10 && granted !== 1'b0; i++) @(negedge core_clk);
    chk({granted, bus_owned}, 2'b00);
    io(1, EXT_BASE, 8'h5A, 0);
    chk(port_wdata, 8'h5A);
  endtask : t_grant
  task results;
    if (fail_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {nrst, req_valid, req_write, req_addr, req_wdata, port_rdata} = '0;
    {audio_src, stall, irq_a, irq_b, audio, want_bus} = '0;
    {fail_count, n_compared} = '0;
    repeat (3) @(negedge core_clk);
    nrst = 1;
    t_speaker;
    t_groups;
    t_card;
    t_wait;
    t_side;
    t_grant;
    results;
  end
endmodule : io_expansion_decode_tb_top
